// >>> hw/vlp_resolver.sv
// vlp_resolver: table base lock and two-level priority resolver
// assumes: request lines and config straps are synchronous to core_clk
//
// Behaviour
// - lock flag blocks table base writes
// - base writes need high enable low, unlocked
// - clear lock only after 55h then AAh
// - set lock only after 55h then AAh
// - single-unlock: clear refused once lock has been set; set any time
// - single-unlock: relock ends unlocking until reset
// - priority by level, then vector order
// - levels only while priority enable set
// - per-source priority bit picks level
// - high request beats pending low requests
// - simultaneous high and low: high first
// - high preempts low routine, low resumes
// - same level never preempts same level
// - vectored mode: equal level by vector order
// - non-vectored: software polls flags in order
// - low enable cleared drops pending low request
// - low enable cleared still resumes running low
// - lower vector number wins, zero highest
// - fixed vector table, 0x57 last, reserved gaps
// - vectored entry address is base plus twice vector
// - multi-vector bit selects vectored or fixed entry address
`timescale 1ns/100ps
module vlp_resolver import vlp_pkg::*; #(
  parameter int NUM_VEC = VLP_NUM_VEC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic single_unlock_config,
  input wire logic multi_vector_config,
  input wire logic [NUM_VEC-1:0] int_request,
  input wire logic [NUM_VEC-1:0] int_enable,
  input wire logic [NUM_VEC-1:0] source_priority_bits,
  vlp_if.ctrl bus
);
  // ------------------------------------------------------------
  // lock key sequencer and table base register
  // ------------------------------------------------------------
  vlp_key_type key_state;
  vlp_key_type next_key_state;
  logic lock_flag;
  logic one_way_spent;
  logic [VLP_BASE_W-1:0] base;
  wire key_is_first = bus.key_data == VLP_KEY_FIRST;
  wire key_is_second = bus.key_data == VLP_KEY_SECOND;
  // lock bit write lands only after the key pair, with nothing but idle cycles in between
  wire lock_armed = key_state == VLP_KEY_ARMED;
  wire unlock_blocked = single_unlock_config && one_way_spent && !bus.lock_data;
  wire lock_write_ok = bus.lock_wr && lock_armed && !unlock_blocked;
  wire base_write_ok = bus.base_wr && !lock_flag && !bus.global_high_int_enable;

  // next key state: any other access in between aborts
  always_comb begin
    next_key_state = VLP_KEY_IDLE;
    if (bus.key_wr) begin
      if (key_is_first) begin
        next_key_state = VLP_KEY_GOT55;
      end else if (key_is_second && key_state == VLP_KEY_GOT55) begin
        next_key_state = VLP_KEY_ARMED;
      end
    end else if (!bus.lock_wr && !bus.base_wr && key_state != VLP_KEY_IDLE && !bus.ack) begin
      next_key_state = key_state; // idle cycles keep the sequence
    end
  end

  // sequencer state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_state <= VLP_KEY_IDLE;
    end else if (clk_en) begin
      key_state <= next_key_state;
    end
  end

  // lock flag, one-way latch and base register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_flag <= 1'b0;
      one_way_spent <= 1'b0;
      base <= VLP_BASE_RESET;
    end else if (clk_en) begin
      if (lock_write_ok) begin
        lock_flag <= bus.lock_data;
        if (bus.lock_data) begin
          one_way_spent <= 1'b1;
        end
      end
      if (base_write_ok) begin
        base <= bus.base_data;
      end
    end
  end

  // ------------------------------------------------------------
  // request resolution
  // ------------------------------------------------------------
  logic [NUM_VEC-1:0] active;
  logic [NUM_VEC-1:0] hi_set;
  logic [NUM_VEC-1:0] lo_set;
  logic [VLP_VEC_W-1:0] hi_vec;
  logic [VLP_VEC_W-1:0] lo_vec;
  logic hi_any;
  logic lo_any;
  vlp_run_type run_state;
  vlp_run_type next_run_state;
  logic [VLP_VEC_W-1:0] vec_q;
  logic [VLP_BASE_W-1:0] addr_q;
  logic [VLP_BASE_W-1:0] taken_q;

  // per-source level select, reserved numbers never request
  genvar g;
  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_src
      assign active[g] = int_request[g] && int_enable[g] && !VLP_RESERVED_MASK[g];
      assign hi_set[g] = active[g] && (source_priority_bits[g] || !bus.priority_levels_enable);
      assign lo_set[g] = active[g] && !source_priority_bits[g] && bus.priority_levels_enable;
    end
  endgenerate

  // lowest set index wins within each level
  always_comb begin
    hi_vec = '0;
    lo_vec = '0;
    hi_any = 1'b0;
    lo_any = 1'b0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (hi_set[i]) begin
        hi_vec = VLP_VEC_W'(i);
        hi_any = 1'b1;
      end
      if (lo_set[i]) begin
        lo_vec = VLP_VEC_W'(i);
        lo_any = 1'b1;
      end
    end
  end

  wire in_high_now = run_state == VLP_RUN_HIGH || run_state == VLP_RUN_HIGH_OVER_LOW;
  wire in_low_now = run_state == VLP_RUN_LOW;
  // high may enter from main or over a low routine, never over itself
  wire high_offer = hi_any && bus.global_high_int_enable && !in_high_now;
  // a low request waits out any routine; dropped when low enable is cleared
  wire low_offer = lo_any && bus.global_low_int_enable && bus.global_high_int_enable && !hi_any
    && run_state == VLP_RUN_MAIN;
  wire [VLP_VEC_W-1:0] pick_vec = high_offer ? hi_vec : lo_vec;
  // vectored address or the two fixed entries
  wire [VLP_BASE_W-1:0] pick_addr = multi_vector_config ?
    base + (VLP_BASE_W'(pick_vec) << VLP_VEC_SCALE_SHIFT) :
    (high_offer ? base : base + VLP_LOW_OFFSET);

  // nesting state machine
  always_comb begin
    next_run_state = run_state;
    unique case (run_state)
      VLP_RUN_MAIN: begin
        if (bus.ack && high_offer) begin
          next_run_state = VLP_RUN_HIGH;
        end else if (bus.ack && low_offer) begin
          next_run_state = VLP_RUN_LOW;
        end
      end
      VLP_RUN_LOW: begin
        if (bus.ack && high_offer) begin
          next_run_state = VLP_RUN_HIGH_OVER_LOW;
        end else if (bus.retfie) begin
          next_run_state = VLP_RUN_MAIN;
        end
      end
      VLP_RUN_HIGH: begin
        if (bus.retfie) begin
          next_run_state = VLP_RUN_MAIN;
        end
      end
      VLP_RUN_HIGH_OVER_LOW: begin
        if (bus.retfie) begin
          next_run_state = VLP_RUN_LOW;
        end
      end
    endcase
  end

  // run state and registered offer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_state <= VLP_RUN_MAIN;
      vec_q <= VLP_VEC_SWI;
      addr_q <= VLP_BASE_RESET;
      taken_q <= VLP_BASE_RESET;
    end else if (clk_en) begin
      run_state <= next_run_state;
      vec_q <= pick_vec;
      addr_q <= pick_addr;
      if (bus.ack && (high_offer || low_offer)) begin
        taken_q <= pick_addr;
      end
    end
  end

  assign bus.table_base_lock_flag = lock_flag;
  assign bus.vector_table_base = base;
  assign bus.req_high = high_offer;
  assign bus.req_low = low_offer;
  assign bus.vec_num = vec_q;
  assign bus.vec_addr = addr_q;
  assign bus.taken_addr = taken_q;
  assign bus.in_high = in_high_now;
  assign bus.in_low = in_low_now;
endmodule

// >>> hw/vlp_pkg.sv
// vlp_pkg: shared constants for the vector lock and priority resolver
// assumes: single core_clk domain, both ends joined by vlp_if
package vlp_pkg;
  localparam int VLP_NUM_VEC = 88;             // vectors 0x00..0x57
  localparam int VLP_VEC_W = 7;
  localparam int VLP_BASE_W = 21;              // table base address width
  localparam logic [7:0] VLP_KEY_FIRST = 8'h55;
  localparam logic [7:0] VLP_KEY_SECOND = 8'hAA;
  localparam logic [VLP_VEC_W-1:0] VLP_VEC_LAST = 7'h57;
  localparam logic [VLP_VEC_W-1:0] VLP_VEC_SWI = 7'h00;
  localparam logic [VLP_VEC_W-1:0] VLP_VEC_DMA1_SRC_CNT = 7'h14;
  localparam logic [VLP_BASE_W-1:0] VLP_BASE_RESET = 21'h000008;
  localparam logic [VLP_BASE_W-1:0] VLP_LOW_OFFSET = 21'h000010; // eight words
  localparam int VLP_VEC_SCALE_SHIFT = 1;      // base + 2*vector
  // reserved vector numbers, one bit per vector
  localparam logic [VLP_NUM_VEC-1:0] VLP_RESERVED_MASK =
    (88'h1 << 8'h0E) | (88'h7 << 8'h11) | (88'h1 << 8'h2B) | (88'h1 << 8'h31) |
    (88'h1 << 8'h3C) | (88'h1 << 8'h44) | (88'h1 << 8'h46) | (88'h3 << 8'h51);
  // lock key sequencer states
  typedef enum logic [1:0] {VLP_KEY_IDLE, VLP_KEY_GOT55, VLP_KEY_ARMED} vlp_key_type;
  // nesting state of the service engine
  typedef enum logic [1:0] {VLP_RUN_MAIN, VLP_RUN_LOW, VLP_RUN_HIGH, VLP_RUN_HIGH_OVER_LOW} vlp_run_type;
endpackage

// >>> hw/vlp_if.sv
// vlp_if: wires between the controller end and the core end
// assumes: the testbench drives core_clk, rst_n and clk_en into both ends
`timescale 1ns/100ps
interface vlp_if;
  import vlp_pkg::*;
  logic key_wr;                                // core writes lock key register
  logic [7:0] key_data;
  logic lock_wr;                               // core writes the lock flag bit
  logic lock_data;
  logic base_wr;                               // core writes vector table base
  logic [VLP_BASE_W-1:0] base_data;
  logic global_high_int_enable;
  logic global_low_int_enable;
  logic priority_levels_enable;
  logic ack;                                   // core takes the offered vector
  logic retfie;                                // core returns from a routine
  logic table_base_lock_flag;
  logic [VLP_BASE_W-1:0] vector_table_base;
  logic req_high;
  logic req_low;
  logic [VLP_VEC_W-1:0] vec_num;
  logic [VLP_BASE_W-1:0] vec_addr;
  logic [VLP_BASE_W-1:0] taken_addr;
  logic in_high;
  logic in_low;
  modport ctrl (input key_wr, key_data, lock_wr, lock_data, base_wr, base_data, global_high_int_enable,
    global_low_int_enable, priority_levels_enable, ack, retfie,
    output table_base_lock_flag, vector_table_base, req_high, req_low, vec_num, vec_addr, taken_addr,
    in_high, in_low);
  modport core (output key_wr, key_data, lock_wr, lock_data, base_wr, base_data, global_high_int_enable,
    global_low_int_enable, priority_levels_enable, ack, retfie,
    input table_base_lock_flag, vector_table_base, req_high, req_low, vec_num, vec_addr, taken_addr,
    in_high, in_low);
endinterface

// >>> hw/vlp_core_end.sv
// vlp_core_end: core-side sequencer driving lock, base and service handshakes
// assumes: user requests are one-cycle pulses on core_clk
`timescale 1ns/100ps
module vlp_core_end import vlp_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cmd_unlock,
  input wire logic cmd_lock,
  input wire logic cmd_base,
  input wire logic [VLP_BASE_W-1:0] cmd_base_value,
  input wire logic cmd_return,
  input wire logic user_high_enable,
  input wire logic user_low_enable,
  input wire logic user_levels_enable,
  output logic busy,
  output logic [VLP_VEC_W-1:0] serviced_vec,
  vlp_if.core bus
);
  // ------------------------------------------------------------
  // key sequence: disable, 55h, AAh, lock bit write, re-enable
  // ------------------------------------------------------------
  typedef enum logic [2:0] {VLP_C_IDLE, VLP_C_KEY1, VLP_C_KEY2, VLP_C_LOCKBIT, VLP_C_BASE} vlp_cstate_type;
  vlp_cstate_type cst;
  logic lock_value;
  logic [VLP_BASE_W-1:0] base_value;
  logic ack_q;

  // step through the sequence, interrupts held off throughout
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cst <= VLP_C_IDLE;
      lock_value <= 1'b0;
      base_value <= VLP_BASE_RESET;
      serviced_vec <= VLP_VEC_SWI;
      ack_q <= 1'b0;
    end else if (clk_en) begin
      unique case (cst)
        VLP_C_IDLE: begin
          if (cmd_unlock || cmd_lock) begin
            cst <= VLP_C_KEY1;
            lock_value <= cmd_lock;
          end else if (cmd_base) begin
            cst <= VLP_C_BASE;
            base_value <= cmd_base_value;
          end
        end
        VLP_C_KEY1: cst <= VLP_C_KEY2;
        VLP_C_KEY2: cst <= VLP_C_LOCKBIT;
        VLP_C_LOCKBIT: cst <= VLP_C_IDLE;
        VLP_C_BASE: cst <= VLP_C_IDLE;
        default: cst <= VLP_C_IDLE;
      endcase
      // vec_num is a registered copy, so it shows the taken offer only in the cycle after ack
      ack_q <= bus.ack;
      if (ack_q) begin
        serviced_vec <= bus.vec_num;
      end
    end
  end

  wire seq_on = cst != VLP_C_IDLE;
  assign busy = seq_on;
  assign bus.key_wr = cst == VLP_C_KEY1 || cst == VLP_C_KEY2;
  assign bus.key_data = cst == VLP_C_KEY2 ? VLP_KEY_SECOND : VLP_KEY_FIRST;
  assign bus.lock_wr = cst == VLP_C_LOCKBIT;
  assign bus.lock_data = lock_value;
  assign bus.base_wr = cst == VLP_C_BASE;
  assign bus.base_data = base_value;
  // high enable forced low while the sequence runs
  assign bus.global_high_int_enable = user_high_enable && !seq_on;
  assign bus.global_low_int_enable = user_low_enable;
  assign bus.priority_levels_enable = user_levels_enable;
  assign bus.ack = !seq_on && (bus.req_high || bus.req_low);
  assign bus.retfie = cmd_return && !seq_on;
endmodule

// >>> verification/vlp_checker_properties.sv
// vlp_checker: concurrent checks on the wires between the two ends
// assumes: clk_en held high throughout; entry address checked only in vectored mode
`timescale 1ns/100ps
module vlp_checker import vlp_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic multi_vector_config,
  input wire logic lock_wr,
  input wire logic lock_data,
  input wire logic base_wr,
  input wire logic [VLP_BASE_W-1:0] base_data,
  input wire logic global_high_int_enable,
  input wire logic global_low_int_enable,
  input wire logic ack,
  input wire logic table_base_lock_flag,
  input wire logic [VLP_BASE_W-1:0] vector_table_base,
  input wire logic req_high,
  input wire logic req_low,
  input wire logic [VLP_VEC_W-1:0] vec_num,
  input wire logic [VLP_BASE_W-1:0] vec_addr,
  input wire logic in_high,
  input wire logic in_low
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // lock flag and table base
  // ------------------------------
  lock_set_a: assert property ($rose(table_base_lock_flag) |-> $past(lock_wr) && $past(lock_data))
    else $error("lock flag set without a lock write");
  lock_clear_a: assert property ($fell(table_base_lock_flag) |-> $past(lock_wr) && !$past(lock_data))
    else $error("lock flag cleared without an unlock write");
  base_gate_a: assert property ($changed(vector_table_base) |->
    $past(base_wr) && !$past(table_base_lock_flag) && !$past(global_high_int_enable))
    else $error("table base changed while locked or enabled");
  base_value_a: assert property (base_wr && !table_base_lock_flag && !global_high_int_enable |=>
    vector_table_base == $past(base_data))
    else $error("accepted base write lost");
  entry_addr_a: assert property (multi_vector_config && $stable(multi_vector_config) &&
    $stable(vector_table_base) |-> vec_addr == vector_table_base + {vec_num, 1'b0})
    else $error("entry address not base plus twice vector");
  // ------------------------------
  // offers and nesting
  // ------------------------------
  low_offer_a: assert property (req_low |-> !req_high && !in_high && !in_low &&
    global_low_int_enable && global_high_int_enable)
    else $error("low offered while high pending or busy");
  high_offer_a: assert property (req_high |-> !in_high && global_high_int_enable)
    else $error("high offered inside a high routine");
  enter_high_a: assert property ($rose(in_high) |-> $past(ack))
    else $error("high routine entered without acknowledge");
  vec_range_a: assert property (vec_num <= VLP_VEC_LAST)
    else $error("vector number beyond last entry");
  lock_cov: cover property ($rose(table_base_lock_flag));
  both_cov: cover property (req_high && global_low_int_enable ##1 in_high);
  preempt_cov: cover property (in_low ##1 in_high);
  base_cov: cover property ($changed(vector_table_base));
endmodule

// >>> verification/tb_top.sv
// tb_top: drives the user sides of both ends joined by one vlp_if
// assumes: core end acknowledges offers by itself and reports serviced_vec
`timescale 1ns/100ps
module tb_top;
  import vlp_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n, clk_en, one_way, multi_vec, busy;
  logic c_unl, c_lck, c_base, c_ret, u_hi, u_lo, u_lvl;
  logic [VLP_NUM_VEC-1:0] req, ien, prio;
  logic [VLP_BASE_W-1:0] base_v;
  logic [VLP_VEC_W-1:0] svc;
  int err_count, n_checks;
  vlp_if bus_if();
  vlp_resolver vlp_resolver_i(.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .single_unlock_config(one_way),
    .multi_vector_config(multi_vec), .int_request(req), .int_enable(ien), .source_priority_bits(prio), .bus(bus_if));
  vlp_core_end vlp_core_end_i(.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_unlock(c_unl),
    .cmd_lock(c_lck), .cmd_base(c_base), .cmd_base_value(base_v), .cmd_return(c_ret), .user_high_enable(u_hi),
    .user_low_enable(u_lo), .user_levels_enable(u_lvl), .busy(busy), .serviced_vec(svc), .bus(bus_if));
  vlp_checker vlp_checker_i(.core_clk(core_clk), .rst_n(rst_n), .multi_vector_config(multi_vec), .lock_wr(bus_if.lock_wr),
    .lock_data(bus_if.lock_data), .base_wr(bus_if.base_wr), .base_data(bus_if.base_data),
    .global_high_int_enable(bus_if.global_high_int_enable), .global_low_int_enable(bus_if.global_low_int_enable),
    .ack(bus_if.ack), .table_base_lock_flag(bus_if.table_base_lock_flag),
    .vector_table_base(bus_if.vector_table_base), .req_high(bus_if.req_high), .req_low(bus_if.req_low),
    .vec_num(bus_if.vec_num), .vec_addr(bus_if.vec_addr), .in_high(bus_if.in_high), .in_low(bus_if.in_low));
  // ------------------------------
  // clock and watchdog
  // ------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #(40 * 4000);
    err_count++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim();
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic check(input logic [VLP_BASE_W-1:0] seen, input logic [VLP_BASE_W-1:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t %s: saw %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic do_reset(input logic ow);
    rst_n = 1'b0;
    one_way = ow;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
  endtask
  // one command pulse: {unlock, lock, base, return}, then wait until idle
  task automatic cmd(input logic [3:0] c, input logic [VLP_BASE_W-1:0] v);
    int k;
    {c_unl, c_lck, c_base, c_ret} = c;
    base_v = v;
    @(negedge core_clk);
    {c_unl, c_lck, c_base, c_ret} = 4'h0;
    repeat (2) @(negedge core_clk);
    for (k = 0; k < 20 && busy !== 1'b0; k++) @(negedge core_clk);
    @(negedge core_clk);
  endtask
  // wait for a routine (m: 10 high, 01 low only, 11 either), compare vector, clear its flag
  task automatic serve(input logic [1:0] m, input logic [VLP_VEC_W-1:0] exp);
    int k;
    for (k = 0; k < 30 && !((m[1] && bus_if.in_high === 1'b1) ||
        (m[0] && bus_if.in_low === 1'b1 && (m[1] || bus_if.in_high === 1'b0))); k++) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    check(VLP_BASE_W'(svc), VLP_BASE_W'(exp), "serviced vector");
    req[exp] = 1'b0;
  endtask
  // ------------------------------
  // test sequence
  // ------------------------------
  initial begin
    {rst_n, clk_en, multi_vec, one_way} = 4'h6;
    {c_unl, c_lck, c_base, c_ret, u_hi, u_lo, u_lvl} = 7'h03;
    {req, prio, base_v} = '0;
    ien = '1;
    do_reset(1'b0);
    check(bus_if.vector_table_base, VLP_BASE_RESET, "base after reset");
    cmd(4'h2, 21'h000100);
    check(bus_if.vector_table_base, 21'h000100, "unlocked base write");
    u_hi = 1'b1;
    cmd(4'h2, 21'h000200);
    check(bus_if.vector_table_base, 21'h000200, "base write drops high enable");
    check(VLP_BASE_W'(bus_if.global_high_int_enable), 21'h1, "high enable restored");
    u_hi = 1'b0;
    cmd(4'h4, 21'h0);
    check(VLP_BASE_W'(bus_if.table_base_lock_flag), 21'h1, "lock set");
    cmd(4'h2, 21'h000300);
    check(bus_if.vector_table_base, 21'h000200, "base write while locked");
    cmd(4'h8, 21'h0);
    cmd(4'h4, 21'h0);
    cmd(4'h8, 21'h0);
    check(VLP_BASE_W'(bus_if.table_base_lock_flag), 21'h0, "repeat unlock");
    $display("test lock done");
    do_reset(1'b1);
    cmd(4'h4, 21'h0);
    cmd(4'h8, 21'h0);
    check(VLP_BASE_W'(bus_if.table_base_lock_flag), 21'h1, "one-way unlock refused");
    $display("test one-way done");
    {u_hi, u_lo, u_lvl} = 3'h7;
    prio[8'h25] = 1'b1;
    prio[8'h30] = 1'b1;
    prio[8'h40] = 1'b1;
    {req[8'h20], req[8'h25], req[8'h30]} = 3'h7;
    serve(2'b10, 7'h25);
    check(bus_if.taken_addr, VLP_BASE_RESET + 21'h00004A, "vectored entry address");
    cmd(4'h1, 21'h0);
    serve(2'b10, 7'h30);
    cmd(4'h1, 21'h0);
    serve(2'b01, 7'h20);
    req[8'h40] = 1'b1;
    serve(2'b10, 7'h40);
    u_lo = 1'b0;
    cmd(4'h1, 21'h0);
    check(VLP_BASE_W'(bus_if.in_low), 21'h1, "low resumes");
    cmd(4'h1, 21'h0);
    {req[8'h21], req[8'h26]} = 2'h3;
    u_lo = 1'b1;
    prio[8'h26] = 1'b1;
    serve(2'b10, 7'h26);
    u_lo = 1'b0;
    cmd(4'h1, 21'h0);
    repeat (5) @(negedge core_clk);
    check(VLP_BASE_W'(bus_if.in_low), 21'h0, "pending low dropped");
    {req[8'h21], u_lo, u_lvl} = 3'h2;
    {req[8'h10], req[8'h30]} = 2'h3;
    serve(2'b11, 7'h10);
    check(VLP_BASE_W'(bus_if.req_high), 21'h0, "no same-level preempt");
    cmd(4'h1, 21'h0);
    serve(2'b11, 7'h30);
    cmd(4'h1, 21'h0);
    req[8'h0E] = 1'b1;
    repeat (10) @(negedge core_clk);
    check(VLP_BASE_W'({bus_if.req_high, bus_if.req_low}), 21'h0, "reserved vector");
    $display("test priority done");
    {req[8'h0E], u_lvl, multi_vec} = 3'h2;
    req[8'h30] = 1'b1;
    serve(2'b10, 7'h30);
    check(bus_if.taken_addr, VLP_BASE_RESET, "fixed high entry");
    cmd(4'h1, 21'h0);
    req[8'h20] = 1'b1;
    serve(2'b01, 7'h20);
    check(bus_if.taken_addr, VLP_BASE_RESET + VLP_LOW_OFFSET, "fixed low entry");
    cmd(4'h1, 21'h0);
    $display("test fixed entries done");
    end_sim();
  end
endmodule
